//--- logic/lmsb_pkg.sv
`default_nettype none
package lmsb_pkg;

   // bus and word widths
   localparam int ADDR_W     = 8;    // apb byte address width
   localparam int DATA_W     = 32;   // apb data width
   localparam int WORD_W     = 24;   // core register width
   localparam int CNT_W      = 25;   // iteration count, holds 2^24
   localparam int HI_BITS    = 8;    // upper bits touched by compat moves
   localparam int LO_W       = 16;   // bits kept by compat moves
   localparam int REG_ID_W   = 4;    // move source/destination id width

   // system stack geometry
   localparam int STK_DEPTH  = 16;   // frames held in flip-flops
   localparam int PTR_W      = 5;    // stack pointer, counts 0..16
   localparam int IDX_W      = 4;    // frame index width
   localparam logic [PTR_W-1:0] STK_FULL = 5'h10;
   localparam logic [PTR_W-1:0] PTR_ONE  = 5'h01;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CCW       = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LOOP_CNT  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CMD       = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_REMAIN    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MOVE_CFG  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MOVE_DATA = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_MOVE_RES  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_MOVE_OLD  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_WIDE      = 8'h24;

   // core_condition_word bit positions
   localparam int BIT_FV = 16;       // forever_loop_indicator
   localparam int BIT_LF = 15;       // loop_active_bit
   localparam int BIT_DM = 14;       // wide_product_mode
   localparam int BIT_SC = 13;       // narrow_compat_mode

   // command register bits, lowest set bit wins
   localparam int CMD_START     = 0; // start counted loop
   localparam int CMD_FOREVER   = 1; // start endless loop
   localparam int CMD_BODY_END  = 2; // last body instruction reached
   localparam int CMD_EXIT      = 3; // leave the current loop early
   localparam int CMD_INT_ENTRY = 4; // long interrupt entry
   localparam int CMD_RTI       = 5; // return_from_interrupt_op
   localparam int CMD_MAC       = 6; // one multiply/mac issued

   // flags register fields
   localparam int FLG_DEPTH_LSB = 0; // stack depth, PTR_W bits
   localparam int FLG_OVF       = 8; // push on full stack, w1c
   localparam int FLG_UNF       = 9; // pull on empty stack, w1c
   localparam int FLG_SKIP      = 10; // zero count skipped, w1c
   localparam int FLG_WDONE     = 11; // wide sequence complete, w1c
   localparam int FLG_SC_EFF    = 12; // compat mode now in force

   // move config fields
   localparam int MCFG_SRC_LSB  = 0;
   localparam int MCFG_DST_LSB  = 4;
   localparam int MCFG_COMBO    = 8; // designated register combination

   // wide product sequencing
   localparam int WIDE_STEP_W   = 2;
   localparam logic [WIDE_STEP_W-1:0] WIDE_LAST = 2'h3;
   localparam logic [WIDE_STEP_W-1:0] WIDE_ONE  = 2'h1;
   localparam int WIDE_ALTER_BIT = 4;

   // compat mode pipeline latency in instruction cycles
   localparam int SC_DELAY_CYC = 3;

   // loop count constants
   localparam logic [CNT_W-1:0] COMPAT_ZERO_CNT = 25'h0010000;
   localparam logic [CNT_W-1:0] CNT_ONE         = 25'h0000001;

   // move register ids
   localparam logic [REG_ID_W-1:0] ID_LA    = 4'h0;
   localparam logic [REG_ID_W-1:0] ID_LC    = 4'h1;
   localparam logic [REG_ID_W-1:0] ID_SP    = 4'h2;
   localparam logic [REG_ID_W-1:0] ID_SSL   = 4'h3;
   localparam logic [REG_ID_W-1:0] ID_SSH   = 4'h4;
   localparam logic [REG_ID_W-1:0] ID_EP    = 4'h5;
   localparam logic [REG_ID_W-1:0] ID_SZ    = 4'h6;
   localparam logic [REG_ID_W-1:0] ID_VBA   = 4'h7;
   localparam logic [REG_ID_W-1:0] ID_MODE  = 4'h8;
   localparam logic [REG_ID_W-1:0] ID_CCW   = 4'h9;
   localparam logic [REG_ID_W-1:0] ID_OMW   = 4'hA;

   // apb request from the master
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } lmsb_apb_req_t;

   // apb answer to the master
   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } lmsb_apb_rsp_t;

   // one system stack frame
   typedef struct packed {
      logic             fv;
      logic             lf;
      logic [CNT_W-1:0] remain;
   } lmsb_frame_t;

endpackage : lmsb_pkg
`default_nettype wire

//--- logic/lmsb_move_trunc.sv
`default_nettype none
module lmsb_move_trunc
   import lmsb_pkg::*;
(
   // mode in force
   input  wire logic                compat,
   // move description
   input  wire logic [REG_ID_W-1:0] src_id,
   input  wire logic [REG_ID_W-1:0] dst_id,
   input  wire logic [WORD_W-1:0]   data,
   input  wire logic [WORD_W-1:0]   old,
   // value that lands in the destination
   output logic      [WORD_W-1:0]   result
);

   logic pcu_src;   // source is a program control register
   logic pcu_dst;   // destination is a program control register
   logic word_src;  // source is a status or mode word
   logic word_dst;  // destination is a status or mode word

   // ids 0 to the mode register id form the program control group
   assign pcu_src  = (src_id <= ID_MODE);
   assign pcu_dst  = (dst_id <= ID_MODE);
   assign word_src = (src_id == ID_CCW) || (src_id == ID_OMW);
   assign word_dst = (dst_id == ID_CCW) || (dst_id == ID_OMW);

   // destination preservation outranks clearing, so a word-to-word
   // move keeps the old upper bits
   always_comb begin
      if (!compat) begin
         result = data;
      end else if (word_dst) begin
         result = {old[WORD_W-1 -: HI_BITS], data[LO_W-1:0]};
      end else if (pcu_src || pcu_dst) begin
         result = {{HI_BITS{1'b0}}, data[LO_W-1:0]};
      end else if (word_src) begin
         result = {{HI_BITS{1'b0}}, data[LO_W-1:0]};
      end else begin
         result = data;
      end
   end

endmodule : lmsb_move_trunc
`default_nettype wire

//--- logic/lmsb_core.sv
// Register access over APB and the address map were chosen for this implementation.
`default_nettype none
// What this block does
// - endless loop start sets forever indicator
// - endless loop end reloads indicator from stack
// - interrupt return restores forever indicator
// - loop active bit enables end-of-body detection
// - loop active bit pushed, reloaded at loop end
// - interrupt return restores loop active bit
// - wide mode chains four multiplies into 96 bits
// - wide mode alters only designated op combinations
// - compat moves via control registers clear top byte, except moves into status words
// - compat moves from status words into non-status registers clear top byte
// - compat moves into status words keep top byte
// - normal mode: zero skips, max runs 2^24-1
// - compat mode: zero runs 2^16 times
// - compat mode change acts three cycles later
module lmsb_core
   import lmsb_pkg::*;
(
   // clock, reset and enable
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          ce,
   // apb register port
   input  wire lmsb_apb_req_t apb_req,
   output var  lmsb_apb_rsp_t apb_rsp,
   // mode and loop state toward the core pipeline
   output logic               forever_loop_indicator,
   output logic               loop_active_bit,
   output logic               loop_end_detect_en,
   output logic               wide_product_mode,
   output logic               narrow_compat_mode,
   output logic               wide_alter
);

   // every flip-flop of the block lives in this one struct
   typedef struct packed {
      logic                          fv;       // forever_loop_indicator
      logic                          lf;       // loop_active_bit
      logic                          dm;       // wide_product_mode
      logic                          sc_req;   // compat mode as written
      logic [SC_DELAY_CYC-1:0]       sc_pipe;  // compat mode delay line
      logic [WORD_W-1:0]             loop_cnt; // loop_iteration_counter
      logic [CNT_W-1:0]              remain;   // iterations still to run
      logic [PTR_W-1:0]              ptr;      // frames on the stack
      lmsb_frame_t [STK_DEPTH-1:0]   stack;    // system stack storage
      logic                          ovf;      // sticky overflow
      logic                          unf;      // sticky underflow
      logic                          skip;     // sticky skipped loop
      logic                          wdone;    // sticky wide sequence end
      logic [REG_ID_W-1:0]           src_id;   // move source id
      logic [REG_ID_W-1:0]           dst_id;   // move destination id
      logic                          combo_ok; // designated combination
      logic [WORD_W-1:0]             move_old; // destination before move
      logic [WORD_W-1:0]             move_res; // destination after move
      logic [WIDE_STEP_W-1:0]        wstep;    // wide sequence position
      logic [DATA_W-1:0]             prdata;   // read data, registered
   } lmsb_state_t;

   lmsb_state_t state;       // registered state
   lmsb_state_t next_state;  // value for the next edge

   // bus phase decode
   logic              setup;      // first cycle of a transfer
   logic              access;     // second cycle, answered at once
   logic              wr;         // write that takes effect now
   logic [ADDR_W-1:0] addr;       // byte address, paddr as given
   logic              mapped;     // address hits a register
   logic [DATA_W-1:0] rd_mux;     // read value for the setup cycle
   logic [DATA_W-1:0] wdata;      // write data alias

   // helpers for loops and the stack
   logic              sc_eff;     // compat mode after the delay
   logic [CNT_W-1:0]  eff_cnt;    // decoded iteration count
   logic [LO_W-1:0]   compat_cnt; // low 16 bits of the loop counter
   logic              push_ok;    // room left on the stack
   logic              pop_ok;     // something left to pull
   logic [IDX_W-1:0]  push_idx;   // frame slot for the next push
   logic [IDX_W-1:0]  pop_idx;    // frame slot of the top entry
   lmsb_frame_t       cur_frame;  // flags as they stand now
   logic [WORD_W-1:0] move_out;   // truncated move result

   // the answer comes in the access cycle itself; a low enable
   // stretches it because nothing may be taken while frozen
   assign setup  = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable;
   assign wr     = access && apb_req.pwrite && ce;
   assign addr   = apb_req.paddr;
   assign wdata  = apb_req.pwdata;

   // handshake is combinational, data comes from a flip-flop
   assign apb_rsp.pready  = access && ce;
   assign apb_rsp.pslverr = access && ce && !mapped;
   assign apb_rsp.prdata  = state.prdata;

   // oldest stage of the delay line is the mode in force
   assign sc_eff = state.sc_pipe[SC_DELAY_CYC-1];

   // count decode depends on the mode in force, not the request
   assign compat_cnt = state.loop_cnt[LO_W-1:0];
   always_comb begin
      if (sc_eff) begin
         // zero means a full 2^16 pass in compat mode
         eff_cnt = (compat_cnt == '0) ? COMPAT_ZERO_CNT
                                      : CNT_W'(compat_cnt);
      end else begin
         // zero stays zero and later skips the body
         eff_cnt = CNT_W'(state.loop_cnt);
      end
   end

   // stack pointers; pop_idx wraps at empty but is then never used
   assign push_ok  = (state.ptr != STK_FULL);
   assign pop_ok   = (state.ptr != '0);
   assign push_idx = state.ptr[IDX_W-1:0];
   assign pop_idx  = IDX_W'(state.ptr - PTR_ONE);
   assign cur_frame.fv     = state.fv;
   assign cur_frame.lf     = state.lf;
   assign cur_frame.remain = state.remain;

   // move truncation follows the mode in force
   lmsb_move_trunc u_trunc (
      .compat (sc_eff),
      .src_id (state.src_id),
      .dst_id (state.dst_id),
      .data   (wdata[WORD_W-1:0]),
      .old    (state.move_old),
      .result (move_out)
   );

   // read multiplexer, sampled into prdata during the setup cycle
   always_comb begin
      rd_mux = '0;
      mapped = 1'b1;
      case (addr)
         OFS_CCW: begin
            rd_mux[BIT_FV] = state.fv;
            rd_mux[BIT_LF] = state.lf;
            rd_mux[BIT_DM] = state.dm;
            rd_mux[BIT_SC] = state.sc_req;
         end
         OFS_LOOP_CNT: begin
            rd_mux[WORD_W-1:0] = state.loop_cnt;
         end
         OFS_CMD: begin
            // commands are pulses, nothing to read back
            rd_mux = '0;
         end
         OFS_REMAIN: begin
            rd_mux[CNT_W-1:0] = state.remain;
         end
         OFS_FLAGS: begin
            rd_mux[FLG_DEPTH_LSB +: PTR_W] = state.ptr;
            rd_mux[FLG_OVF]    = state.ovf;
            rd_mux[FLG_UNF]    = state.unf;
            rd_mux[FLG_SKIP]   = state.skip;
            rd_mux[FLG_WDONE]  = state.wdone;
            rd_mux[FLG_SC_EFF] = sc_eff;
         end
         OFS_MOVE_CFG: begin
            rd_mux[MCFG_SRC_LSB +: REG_ID_W] = state.src_id;
            rd_mux[MCFG_DST_LSB +: REG_ID_W] = state.dst_id;
            rd_mux[MCFG_COMBO]               = state.combo_ok;
         end
         OFS_MOVE_DATA: begin
            // write-only trigger, reads as zero
            rd_mux = '0;
         end
         OFS_MOVE_RES: begin
            rd_mux[WORD_W-1:0] = state.move_res;
         end
         OFS_MOVE_OLD: begin
            rd_mux[WORD_W-1:0] = state.move_old;
         end
         OFS_WIDE: begin
            rd_mux[WIDE_STEP_W-1:0]  = state.wstep;
            rd_mux[WIDE_ALTER_BIT]   = state.dm && state.combo_ok;
         end
         default: begin
            // unmapped: zero data and an error answer
            mapped = 1'b0;
         end
      endcase
   end

   // next state: bus writes first, commands after them
   always_comb begin
      next_state = state;
      if (ce) begin
         // delay line advances one stage per instruction cycle
         next_state.sc_pipe = {state.sc_pipe[SC_DELAY_CYC-2:0],
                               state.sc_req};

         // capture read data so prdata is a flop in the access cycle
         if (setup) begin
            next_state.prdata = rd_mux;
         end

         // plain register writes
         if (wr) begin
            case (addr)
               OFS_CCW: begin
                  // only the mode bits are writable; loop flags are
                  // owned by the sequencer below
                  next_state.dm     = wdata[BIT_DM];
                  next_state.sc_req = wdata[BIT_SC];
               end
               OFS_LOOP_CNT: begin
                  next_state.loop_cnt = wdata[WORD_W-1:0];
               end
               OFS_FLAGS: begin
                  // write one to clear; a set below still wins
                  if (wdata[FLG_OVF]) begin
                     next_state.ovf = 1'b0;
                  end
                  if (wdata[FLG_UNF]) begin
                     next_state.unf = 1'b0;
                  end
                  if (wdata[FLG_SKIP]) begin
                     next_state.skip = 1'b0;
                  end
                  if (wdata[FLG_WDONE]) begin
                     next_state.wdone = 1'b0;
                  end
               end
               OFS_MOVE_CFG: begin
                  next_state.src_id   = wdata[MCFG_SRC_LSB +: REG_ID_W];
                  next_state.dst_id   = wdata[MCFG_DST_LSB +: REG_ID_W];
                  next_state.combo_ok = wdata[MCFG_COMBO];
               end
               OFS_MOVE_OLD: begin
                  next_state.move_old = wdata[WORD_W-1:0];
               end
               OFS_MOVE_DATA: begin
                  // the move itself: result seen through move_res
                  next_state.move_res = move_out;
               end
               default: begin
                  // read-only or unmapped: write has no effect
               end
            endcase
         end

         // commands; lowest set bit wins so one frame moves per write
         if (wr && (addr == OFS_CMD)) begin
            if (wdata[CMD_START]) begin
               if (eff_cnt == '0) begin
                  // zero count in normal mode never enters the body
                  next_state.skip = 1'b1;
               end else if (!push_ok) begin
                  next_state.ovf = 1'b1;
               end else begin
                  next_state.stack[push_idx] = cur_frame;
                  next_state.ptr    = state.ptr + PTR_ONE;
                  next_state.lf     = 1'b1;
                  next_state.fv     = 1'b0;
                  next_state.remain = eff_cnt;
               end
            end else if (wdata[CMD_FOREVER]) begin
               if (!push_ok) begin
                  next_state.ovf = 1'b1;
               end else begin
                  // the old indicator goes on the stack for nesting
                  next_state.stack[push_idx] = cur_frame;
                  next_state.ptr    = state.ptr + PTR_ONE;
                  next_state.lf     = 1'b1;
                  next_state.fv     = 1'b1;
                  next_state.remain = '0;
               end
            end else if (wdata[CMD_BODY_END]) begin
               // end detection only works while a loop is active
               if (state.lf && !state.fv) begin
                  if (state.remain > CNT_ONE) begin
                     next_state.remain = state.remain - CNT_ONE;
                  end else if (pop_ok) begin
                     next_state.fv     = state.stack[pop_idx].fv;
                     next_state.lf     = state.stack[pop_idx].lf;
                     next_state.remain = state.stack[pop_idx].remain;
                     next_state.ptr    = state.ptr - PTR_ONE;
                  end else begin
                     next_state.unf = 1'b1;
                  end
               end
            end else if (wdata[CMD_EXIT]) begin
               // early exit; with an interrupt return, the only way out of an endless loop
               if (state.lf && pop_ok) begin
                  next_state.fv     = state.stack[pop_idx].fv;
                  next_state.lf     = state.stack[pop_idx].lf;
                  next_state.remain = state.stack[pop_idx].remain;
                  next_state.ptr    = state.ptr - PTR_ONE;
               end else if (state.lf) begin
                  next_state.unf = 1'b1;
               end
            end else if (wdata[CMD_INT_ENTRY]) begin
               // long interrupt saves the loop context unchanged
               if (push_ok) begin
                  next_state.stack[push_idx] = cur_frame;
                  next_state.ptr = state.ptr + PTR_ONE;
               end else begin
                  next_state.ovf = 1'b1;
               end
            end else if (wdata[CMD_RTI]) begin
               if (pop_ok) begin
                  next_state.fv     = state.stack[pop_idx].fv;
                  next_state.lf     = state.stack[pop_idx].lf;
                  next_state.remain = state.stack[pop_idx].remain;
                  next_state.ptr    = state.ptr - PTR_ONE;
               end else begin
                  next_state.unf = 1'b1;
               end
            end else if (wdata[CMD_MAC]) begin
               // only designated combinations advance the sequence;
               // other operations run as normal arithmetic
               if (state.dm && state.combo_ok) begin
                  next_state.wstep = state.wstep + WIDE_ONE;
                  if (state.wstep == WIDE_LAST) begin
                     next_state.wdone = 1'b1;
                  end
               end
            end
         end

         // leaving wide mode abandons a half-done sequence
         if (!state.dm) begin
            next_state.wstep = '0;
         end
      end
   end

   // single register stage, synchronous reset clears everything
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // core-facing outputs straight from the state
   assign forever_loop_indicator = state.fv;
   assign loop_active_bit        = state.lf;
   assign loop_end_detect_en     = state.lf;
   assign wide_product_mode      = state.dm;
   assign narrow_compat_mode     = sc_eff;
   assign wide_alter             = state.dm && state.combo_ok;

endmodule : lmsb_core
`default_nettype wire

//--- tb/lmsb_assertions.sv
`default_nettype none
module lmsb_assertions
   import lmsb_pkg::*;
(
   // clock and reset
   input wire logic          core_clk,
   input wire logic          rst,
   input wire logic          ce,
   // register port
   input wire lmsb_apb_req_t apb_req,
   input wire lmsb_apb_rsp_t apb_rsp,
   // status outputs
   input wire logic          forever_loop_indicator,
   input wire logic          loop_active_bit,
   input wire logic          loop_end_detect_en,
   input wire logic          wide_product_mode,
   input wire logic          narrow_compat_mode,
   input wire logic          wide_alter
);
   // a write that completes at this edge
   wire logic acc = apb_req.psel & apb_req.penable & apb_req.pwrite & ce;
   wire logic ccw_wr = acc & (apb_req.paddr == OFS_CCW);
   wire logic cmd_wr = acc & (apb_req.paddr == OFS_CMD);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_fv_set_cause: assert property ($rose(forever_loop_indicator)
      |-> $past(cmd_wr)) else $error("fv rose without a command");
   chk_fv_pop_cause: assert property ($fell(forever_loop_indicator)
      |-> $past(cmd_wr)) else $error("fv fell without a command");
   chk_fv_needs_lf: assert property (forever_loop_indicator
      |-> loop_active_bit) else $error("fv set outside a loop");
   chk_detect_follow: assert property (loop_end_detect_en
      == loop_active_bit) else $error("end detect differs from lf");
   chk_lf_cause: assert property ($changed(loop_active_bit)
      |-> $past(cmd_wr)) else $error("lf moved without a command");
   chk_dm_cause: assert property ($changed(wide_product_mode)
      |-> $past(ccw_wr)) else $error("dm moved without a write");
   chk_alter_dm: assert property (wide_alter
      |-> wide_product_mode) else $error("alter without wide mode");
   chk_sc_delay: assert property ($changed(narrow_compat_mode)
      |-> $past(ccw_wr, 4)) else $error("compat mode moved off time");
   cover property ($rose(forever_loop_indicator));
   cover property ($rose(narrow_compat_mode));
   cover property ($rose(wide_alter));
endmodule : lmsb_assertions
bind lmsb_core lmsb_assertions u_chk (.core_clk, .rst, .ce, .apb_req,
   .apb_rsp, .forever_loop_indicator, .loop_active_bit,
   .loop_end_detect_en, .wide_product_mode, .narrow_compat_mode,
   .wide_alter);
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench
   import lmsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          core_clk, rst, ce, fv, lf, led, dm, sc, wa, err;
   lmsb_apb_req_t req;
   lmsb_apb_rsp_t rsp;
   logic [31:0]   q;            // last read data
   int            num_errors = 0;
   int            num_checks = 0;
   lmsb_core u_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
      .apb_req(req), .apb_rsp(rsp), .forever_loop_indicator(fv),
      .loop_active_bit(lf), .loop_end_detect_en(led),
      .wide_product_mode(dm), .narrow_compat_mode(sc), .wide_alter(wa));
   // 20 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // one apb transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge core_clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         num_errors++;
         test_done;
      end
      q = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      #1; // let the completing edge land before outputs are looked at
   endtask : apb
   task automatic stat(input logic ef, el);
      chk("fv", {31'h0, ef}, {31'h0, fv});
      chk("lf", {31'h0, el}, {31'h0, lf});
      chk("detect", {31'h0, el}, {31'h0, led});
   endtask : stat
   function automatic logic [23:0] mv(logic s, logic [3:0] a, b,
                                      logic [23:0] d, o);
      if (!s) return d;
      if (b == ID_CCW || b == ID_OMW) return {o[23:16], d[15:0]};
      if (a <= ID_MODE || b <= ID_MODE || a == ID_CCW || a == ID_OMW)
         return {8'h00, d[15:0]};
      return d;
   endfunction : mv
   // random moves through every source and destination kind
   task automatic moves(input logic s);
      logic [3:0]  a, b;
      logic [23:0] d, o;
      for (int i = 0; i < 24; i++) begin
         a = 4'($urandom);
         b = 4'($urandom);
         d = 24'($urandom);
         o = 24'($urandom);
         apb(1, OFS_MOVE_CFG, {24'h0, b, a});
         apb(1, OFS_MOVE_OLD, {8'h00, o});
         apb(1, OFS_MOVE_DATA, {8'h00, d});
         apb(0, OFS_MOVE_RES, 32'h0);
         chk("move", {8'h00, mv(s, a, b, d, o)}, q);
      end
      $display("test moves done");
   endtask : moves
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      req = '0;
      q = '0;
      void'($urandom(93406));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      apb(0, OFS_CCW, 32'h0);
      chk("ccw reset", 32'h0, q);
      // nested loops, an interrupt and its return
      apb(1, OFS_LOOP_CNT, 32'h3);
      apb(1, OFS_CMD, 32'h1);
      stat(0, 1);
      apb(1, OFS_CMD, 32'h2);
      stat(1, 1);
      apb(1, OFS_CMD, 32'h1);
      stat(0, 1);
      apb(1, OFS_CMD, 32'h8);
      stat(1, 1);
      apb(1, OFS_CMD, 32'h8);
      stat(0, 1);
      apb(1, OFS_CMD, 32'h10);
      apb(1, OFS_CMD, 32'h2);
      apb(1, OFS_CMD, 32'h20);
      stat(0, 1);
      apb(1, OFS_CMD, 32'h20);
      apb(1, OFS_CMD, 32'h4);
      apb(1, OFS_CMD, 32'h4);
      stat(0, 1);
      apb(1, OFS_CMD, 32'h4);
      stat(0, 0);
      // zero count skips, full count loads
      apb(1, OFS_LOOP_CNT, 32'h0);
      apb(1, OFS_CMD, 32'h1);
      stat(0, 0);
      apb(0, OFS_FLAGS, 32'h0);
      chk("skip", 32'h1, {31'h0, q[FLG_SKIP]});
      apb(1, OFS_LOOP_CNT, 32'hFFFFFF);
      apb(1, OFS_CMD, 32'h1);
      apb(0, OFS_REMAIN, 32'h0);
      chk("remain", 32'hFFFFFF, q);
      apb(1, OFS_CMD, 32'h8);
      $display("test loops done");
      moves(0);
      // compat mode takes three cycles to act
      apb(1, OFS_CCW, 32'h2000);
      repeat (2) @(posedge core_clk);
      #1 chk("sc early", 32'h0, {31'h0, sc});
      @(posedge core_clk);
      #1 chk("sc late", 32'h1, {31'h0, sc});
      apb(1, OFS_LOOP_CNT, 32'h0);
      apb(1, OFS_CMD, 32'h1);
      apb(0, OFS_REMAIN, 32'h0);
      chk("remain zero", 32'h10000, q);
      apb(1, OFS_CMD, 32'h8);
      apb(1, OFS_LOOP_CNT, {8'h00, 8'($urandom), 16'hFFFF});
      apb(1, OFS_CMD, 32'h1);
      apb(0, OFS_REMAIN, 32'h0);
      chk("remain max", 32'hFFFF, q);
      apb(1, OFS_CMD, 32'h8);
      moves(1);
      // wide product sequence of four
      apb(1, OFS_CCW, 32'h6000);
      apb(1, OFS_MOVE_CFG, 32'h100);
      chk("alter", 32'h1, {31'h0, wa});
      repeat (3) apb(1, OFS_CMD, 32'h40);
      apb(0, OFS_WIDE, 32'h0);
      chk("step", 32'h3, {30'h0, q[1:0]});
      apb(1, OFS_CMD, 32'h40);
      apb(0, OFS_FLAGS, 32'h0);
      chk("wide done", 32'h1, {31'h0, q[FLG_WDONE]});
      apb(1, OFS_MOVE_CFG, 32'h0);
      chk("no alter", 32'h0, {31'h0, wa});
      apb(1, OFS_CCW, 32'h0);
      chk("dm off", 32'h0, {31'h0, dm});
      // unmapped address is refused
      apb(0, 8'h40, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, q);
      $display("test modes done");
      test_done;
   end
endmodule : testbench
`default_nettype wire
